/* src/eip_pkg.sv */
// Package for the pin-function block: register map, field positions, resets.
// Assumes a 32-bit APB slave with one aligned word per register.
package eip_pkg;
    localparam logic [7:0] EIP_OFS_CTRL    = 8'h00;
    localparam logic [7:0] EIP_OFS_CLKO    = 8'h04;
    localparam logic [7:0] EIP_OFS_IRQ_ST  = 8'h08;
    localparam logic [7:0] EIP_OFS_IRQ_CLR = 8'h0C;
    localparam logic [7:0] EIP_OFS_IRQ_EN  = 8'h10;
    localparam logic [7:0] EIP_OFS_PORT    = 8'h14;
    localparam logic [7:0] EIP_OFS_STATUS  = 8'h18;
    localparam logic [7:0] EIP_OFS_UID     = 8'h1C;
    // Control word fields
    localparam int EIP_CTRL_SEL_A   = 0;
    localparam int EIP_CTRL_SEL_B   = 2;
    localparam int EIP_CTRL_DIV_LO  = 4;
    localparam int EIP_CTRL_DIV_HI  = 5;
    localparam int EIP_CTRL_RSTOUT  = 6;
    localparam int EIP_CTRL_PD      = 7;
    // Clock-output enable fields
    localparam int EIP_CLKO_A       = 0;
    localparam int EIP_CLKO_B       = 2;
    // Interrupt status layout: a,b,c,d,e
    localparam int EIP_NIRQ         = 5;
    localparam int EIP_IRQ_A        = 0;
    localparam int EIP_IRQ_B        = 1;
    localparam int EIP_IRQ_C        = 2;
    localparam int EIP_IRQ_D        = 3;
    localparam int EIP_IRQ_E        = 4;
    localparam logic [7:0]  EIP_CTRL_RST  = 8'h00;
    localparam logic [2:0]  EIP_CLKO_RST  = 3'h0;
    localparam logic [1:0]  EIP_DIV_OFF   = 2'h0;
    localparam logic [1:0]  EIP_DIV_1     = 2'h1;
    localparam logic [1:0]  EIP_DIV_2     = 2'h2;
    localparam logic [1:0]  EIP_DIV_4     = 2'h3;
    // Pin reset: two machine cycles, one clock each
    localparam int          EIP_RST_MIN_CYC = 2;
    localparam int          EIP_UID_BYTES   = 7;
    localparam int          EIP_FLASH_BYTES = 512;
endpackage : eip_pkg

/* src/eip_pin_func.sv */
// Pin functions of a small eight-pin controller: five external interrupts,
// clock-output steering, master clock divider, pin reset, reset indicator.
// Assumes pins synchronous to pclk and a single APB master.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module eip_pin_func
    import eip_pkg::*;
#(
    parameter int          FLASH_BYTES = EIP_FLASH_BYTES,
    parameter logic [55:0] UID_VALUE   = 56'h0123456789ABCD  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt pins
    input  wire logic        edge_irq_a,
    input  wire logic        edge_irq_b,
    input  wire logic        fall_irq_c,
    input  wire logic        fall_irq_d,
    input  wire logic        fall_irq_e,
    // Programming-time option, counter clocks and master clock
    input  wire logic        reset_pin_option,
    input  wire logic        counter_a_clock_out,
    input  wire logic        counter_b_clock_out,
    input  wire logic        master_clock,
    // Shared pin drivers, oe low while driving
    output logic             pin_c0_out,
    output logic             pin_c0_oe_n,
    output logic             pin_c5_out,
    output logic             pin_c5_oe_n,
    output logic             master_clock_out_pin,
    output logic             master_clock_out_oe_n,
    output logic             reset_indicator_out,
    // System side
    output logic             irq,
    output logic             wake,
    output logic             pin_reset_req
);
    typedef struct packed {
        logic [7:0]          ctrl;
        logic [2:0]          clko;
        logic [EIP_NIRQ-1:0] st;
        logic [EIP_NIRQ-1:0] en;
        logic [EIP_NIRQ-1:0] s1;
        logic [EIP_NIRQ-1:0] s2;
        logic [EIP_NIRQ-1:0] prev;
        logic [1:0]          hi_cnt;
        logic                in_reset;
        logic [1:0]          div_cnt;
        logic                mclk_q;
        logic [31:0]         rdata;
        logic                ready;
        logic                err;
        logic                irq;
        logic                wake;
        logic                c0;
        logic                c0_oe_n;
        logic                c5;
        logic                c5_oe_n;
        logic                mco;
        logic                mco_oe_n;
        logic                rso;
    } eip_state_t;

    eip_state_t st_r;
    eip_state_t st_nxt;

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == EIP_OFS_CTRL) || (a == EIP_OFS_CLKO) || (a == EIP_OFS_IRQ_ST) ||
                     (a == EIP_OFS_IRQ_CLR) || (a == EIP_OFS_IRQ_EN) ||
                     (a == EIP_OFS_PORT) || (a == EIP_OFS_STATUS) || (a == EIP_OFS_UID);
    endfunction : known_addr

    logic [EIP_NIRQ-1:0] pins;
    logic [EIP_NIRQ-1:0] fall;
    logic [EIP_NIRQ-1:0] rise;
    logic [EIP_NIRQ-1:0] ev;
    logic [EIP_NIRQ-1:0] clr;
    logic                wr;
    logic                rd_phase;
    logic                div_tick;

    assign pins = {fall_irq_e, fall_irq_d, fall_irq_c, edge_irq_b, edge_irq_a};

    always_comb begin
        st_nxt   = st_r;
        // Second stage feeds edge logic, port readback and pin reset; first stage stays clean
        st_nxt.s1   = pins;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
        fall = st_r.prev & ~st_r.s2;
        rise = ~st_r.prev & st_r.s2;
        ev   = '0;
        ev[EIP_IRQ_A] = fall[EIP_IRQ_A] |
                        (rise[EIP_IRQ_A] & ~st_r.ctrl[EIP_CTRL_SEL_A]);
        ev[EIP_IRQ_B] = fall[EIP_IRQ_B] |
                        (rise[EIP_IRQ_B] & ~st_r.ctrl[EIP_CTRL_SEL_B]);
        ev[EIP_IRQ_C] = fall[EIP_IRQ_C];
        ev[EIP_IRQ_D] = fall[EIP_IRQ_D];
        ev[EIP_IRQ_E] = fall[EIP_IRQ_E];

        // APB: zero-wait, answered in the access cycle
        // Access cycle is the one in which ready stands
        wr       = psel & penable & pwrite & st_r.ready;
        rd_phase = psel & ~penable;
        clr      = '0;
        st_nxt.ready = psel & ~penable;
        st_nxt.err   = psel & ~penable & ~known_addr(paddr);
        if (wr) begin
            case (paddr)
                EIP_OFS_CTRL:    st_nxt.ctrl = pwdata[7:0];
                EIP_OFS_CLKO: begin
                    // Only the two steering bits exist
                    st_nxt.clko[EIP_CLKO_A] = pwdata[EIP_CLKO_A];
                    st_nxt.clko[EIP_CLKO_B] = pwdata[EIP_CLKO_B];
                end
                EIP_OFS_IRQ_CLR: clr         = pwdata[EIP_NIRQ-1:0];
                EIP_OFS_IRQ_EN:  st_nxt.en   = pwdata[EIP_NIRQ-1:0];
                default:         st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        // Set wins over a clear in the same cycle
        st_nxt.st = (st_r.st & ~clr) | ev;
        st_nxt.irq = |(st_nxt.st & st_nxt.en);
        st_nxt.rdata = st_r.rdata;
        if (rd_phase) begin
            case (paddr)
                EIP_OFS_CTRL:   st_nxt.rdata = {24'h000000, st_r.ctrl};
                EIP_OFS_CLKO:   st_nxt.rdata = {29'h00000000, st_r.clko};
                EIP_OFS_IRQ_ST: st_nxt.rdata = {27'h0000000, st_r.st};
                EIP_OFS_IRQ_EN: st_nxt.rdata = {27'h0000000, st_r.en};
                EIP_OFS_PORT:   st_nxt.rdata = {27'h0000000, st_r.s2};
                EIP_OFS_STATUS: st_nxt.rdata = {30'h00000000, st_r.in_reset,
                                                st_r.wake};
                // Register returns the low four bytes of the identifier; upper bytes are not readable
                EIP_OFS_UID:    st_nxt.rdata = UID_VALUE[31:0];
                default:        st_nxt.rdata = 32'h00000000;
            endcase
        end

        // Wake pulses while power-down flag set; c,d,e edges and b edges as selected, not gated by the interrupt enables
        st_nxt.wake = st_r.ctrl[EIP_CTRL_PD] &
                      (ev[EIP_IRQ_B] | ev[EIP_IRQ_C] | ev[EIP_IRQ_D] | ev[EIP_IRQ_E]);
        if (st_nxt.wake) begin
            st_nxt.ctrl[EIP_CTRL_PD] = 1'b0;
        end

        // Pin reset: pin c shares with reset function when option set
        st_nxt.hi_cnt = st_r.hi_cnt;
        if (reset_pin_option && st_r.s2[EIP_IRQ_C]) begin
            if (st_r.hi_cnt != 2'(EIP_RST_MIN_CYC)) begin
                st_nxt.hi_cnt = st_r.hi_cnt + 2'h1;
            end
        end else begin
            st_nxt.hi_cnt = 2'h0;
        end
        st_nxt.in_reset = (st_nxt.hi_cnt == 2'(EIP_RST_MIN_CYC));
        if (st_nxt.in_reset) begin
            st_nxt.ctrl = EIP_CTRL_RST;
            st_nxt.clko = EIP_CLKO_RST;
            st_nxt.st   = '0;
            st_nxt.en   = '0;
            st_nxt.irq  = 1'b0;
        end

        // Indicator low through reset, then software controlled
        st_nxt.rso = st_nxt.ctrl[EIP_CTRL_RSTOUT] & ~st_nxt.in_reset;

        // Counter clock steering
        st_nxt.c0      = st_r.clko[EIP_CLKO_B] & counter_b_clock_out;
        st_nxt.c0_oe_n = ~st_r.clko[EIP_CLKO_B];
        st_nxt.c5      = st_r.clko[EIP_CLKO_A] & counter_a_clock_out;
        st_nxt.c5_oe_n = ~st_r.clko[EIP_CLKO_A];

        // Master clock divider; source sampled as plain input
        st_nxt.mclk_q  = master_clock;
        div_tick       = master_clock & ~st_r.mclk_q;
        st_nxt.div_cnt = div_tick ? st_r.div_cnt + 2'h1 : st_r.div_cnt;
        case ({st_r.ctrl[EIP_CTRL_DIV_HI], st_r.ctrl[EIP_CTRL_DIV_LO]})
            EIP_DIV_OFF: begin
                st_nxt.mco      = 1'b0;
                st_nxt.mco_oe_n = 1'b1;
            end
            EIP_DIV_1: begin
                st_nxt.mco      = master_clock;
                st_nxt.mco_oe_n = 1'b0;
            end
            EIP_DIV_2: begin
                st_nxt.mco      = st_r.div_cnt[0];
                st_nxt.mco_oe_n = 1'b0;
            end
            EIP_DIV_4: begin
                st_nxt.mco      = st_r.div_cnt[1];
                st_nxt.mco_oe_n = 1'b0;
            end
            default: begin
                st_nxt.mco      = 1'b0;
                st_nxt.mco_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            // Pins idle high; avoids a false rising edge after reset
            st_r.s1       <= '1;
            st_r.s2       <= '1;
            st_r.prev     <= '1;
            st_r.c0_oe_n  <= 1'b1;
            st_r.c5_oe_n  <= 1'b1;
            st_r.mco_oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata                = st_r.rdata;
    assign pready                = st_r.ready;
    assign pslverr               = st_r.err;
    assign irq                   = st_r.irq;
    assign wake                  = st_r.wake;
    assign pin_reset_req         = st_r.in_reset;
    assign pin_c0_out            = st_r.c0;
    assign pin_c0_oe_n           = st_r.c0_oe_n;
    assign pin_c5_out            = st_r.c5;
    assign pin_c5_oe_n           = st_r.c5_oe_n;
    assign master_clock_out_pin  = st_r.mco;
    assign master_clock_out_oe_n = st_r.mco_oe_n;
    assign reset_indicator_out   = st_r.rso;
endmodule : eip_pin_func

/* bench/eip_pin_src.sv */
// Pin-side sources: interrupt pins, counter clocks, master clock.
// Assumes the bench calls drive() from its main sequence only.
`timescale 1ns/1ps
module eip_pin_src (
    // Clock
    input  wire logic       pclk,
    // Pins towards the block
    output logic      [4:0] pins,
    output logic            cnt_a_clk,
    output logic            cnt_b_clk,
    output logic            mclk
);
    logic [3:0] div_r = 4'h0;
    initial pins = 5'h1F;
    // Slow sources so every change is seen on pclk
    always @(posedge pclk) div_r <= div_r + 4'h1;
    assign mclk      = div_r[1];
    assign cnt_a_clk = div_r[2];
    assign cnt_b_clk = div_r[3];
    // Pins idle high; a low is a falling edge
    task automatic drive(input int idx, input logic val, input int hold);
        @(posedge pclk);
        pins[idx] <= val;
        repeat (hold) @(posedge pclk);
    endtask : drive
endmodule : eip_pin_src

/* bench/eip_pin_func_properties.sv */
// Port-level checker for the pin-function block.
// Assumes one clock, pclk, and async active-low presetn.
`timescale 1ns/1ps
module eip_pin_func_properties (
    // Clock, reset, bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and straps
    input wire logic fall_irq_c,
    input wire logic reset_pin_option,
    input wire logic counter_a_clock_out,
    input wire logic counter_b_clock_out,
    // Outputs watched
    input wire logic pin_c0_out,
    input wire logic pin_c0_oe_n,
    input wire logic pin_c5_out,
    input wire logic pin_c5_oe_n,
    input wire logic reset_indicator_out,
    input wire logic wake,
    input wire logic pin_reset_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence pin_held_s; (reset_pin_option && fall_irq_c) [*5]; endsequence
    zero_wait_a: assert property (setup_s |=> pready) else $error("ready late");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("stray slverr");
    wake_pulse_a: assert property (wake |=> !wake) else $error("wake too long");
    reset_cause_a: assert property ($rose(pin_reset_req) |-> reset_pin_option
        && $past(fall_irq_c)) else $error("pin reset without cause");
    reset_entry_a: assert property (pin_held_s |=> pin_reset_req)
        else $error("pin reset missed");
    indicator_low_a: assert property (pin_reset_req [*2] |-> !reset_indicator_out)
        else $error("indicator high in reset");
    steer_b_a: assert property (!pin_c0_oe_n [*2] |-> pin_c0_out == $past(counter_b_clock_out))
        else $error("counter b output wrong");
    steer_a_a: assert property (!pin_c5_oe_n [*2] |-> pin_c5_out == $past(counter_a_clock_out))
        else $error("counter a output wrong");
endmodule : eip_pin_func_properties
bind eip_pin_func eip_pin_func_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .fall_irq_c(fall_irq_c), .reset_pin_option(reset_pin_option),
    .counter_a_clock_out(counter_a_clock_out), .counter_b_clock_out(counter_b_clock_out),
    .pin_c0_out(pin_c0_out), .pin_c0_oe_n(pin_c0_oe_n), .pin_c5_out(pin_c5_out),
    .pin_c5_oe_n(pin_c5_oe_n), .reset_indicator_out(reset_indicator_out), .wake(wake),
    .pin_reset_req(pin_reset_req));

/* bench/testbench.sv */
// Self-checking bench: APB master here, pins from the partner model.
// Assumes zero-wait APB and pins sampled on pclk.
`timescale 1ns/1ps
module testbench;
    import eip_pkg::*;
    localparam logic [55:0] UID = 56'h13579BDF02468A;  // Arbitrary value
    logic        pclk, presetn, psel, penable, pwrite, opt, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        c0, c0n, c5, c5n, mco, mcon, rsto, irq, wake, prr, ca, cb, mclk;
    logic [4:0]  pins;
    int          n_errors, checked, cyc, n_wake;
    eip_pin_func #(.UID_VALUE(UID)) u_eip_pin_func (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .edge_irq_a(pins[0]),
        .edge_irq_b(pins[1]), .fall_irq_c(pins[2]), .fall_irq_d(pins[3]),
        .fall_irq_e(pins[4]), .reset_pin_option(opt), .counter_a_clock_out(ca),
        .counter_b_clock_out(cb), .master_clock(mclk), .pin_c0_out(c0), .pin_c0_oe_n(c0n),
        .pin_c5_out(c5), .pin_c5_oe_n(c5n), .master_clock_out_pin(mco),
        .master_clock_out_oe_n(mcon), .reset_indicator_out(rsto), .irq(irq), .wake(wake),
        .pin_reset_req(prr));
    eip_pin_src u_eip_pin_src (.pclk(pclk), .pins(pins), .cnt_a_clk(ca), .cnt_b_clk(cb),
        .mclk(mclk));
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    // Wake is a one-cycle pulse, so count it here
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (wake === 1'b1) n_wake <= n_wake + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready and data taken at the rising edge that ends the access
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask : rdc
    function automatic logic [31:0] exp_st(int i, int m, bit rising);
        return (!rising || (i < 2 && m == 0)) ? 32'h1 << i : 32'h0;
    endfunction : exp_st
    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        int w, tg;
        logic [31:0] v, r;
        logic e;
        void'($urandom(66));
        {presetn, psel, penable, pwrite, opt, paddr, pwdata} = '0;
        {n_errors, checked, cyc, n_wake} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset_ind", 32'h0, rsto);
        chk("pin_rst_off", 32'h0, prr);
        chk("oe_n", 32'h7, {c0n, c5n, mcon});
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("slverr", 32'h1, e);
        rdc("uid", EIP_OFS_UID, UID[31:0]);
        for (int i = 0; i < EIP_NIRQ; i++) for (int m = 0; m < 2; m++) begin
            wr(EIP_OFS_CTRL, (m << EIP_CTRL_SEL_A) | (m << EIP_CTRL_SEL_B) | 32'h80);
            wr(EIP_OFS_IRQ_CLR, 32'h1F);
            wr(EIP_OFS_IRQ_EN, 32'h1F);
            w = n_wake;
            u_eip_pin_src.drive(i, 1'b0, 6);
            rdc("st_fall", EIP_OFS_IRQ_ST, exp_st(i, m, 0));
            chk("irq", 32'h1, irq);
            if (i > 0) chk("wake", 32'h1, n_wake - w);
            wr(EIP_OFS_IRQ_CLR, 32'h1 << i);
            u_eip_pin_src.drive(i, 1'b1, 6);
            rdc("st_rise", EIP_OFS_IRQ_ST, exp_st(i, m, 1));
        end
        wr(EIP_OFS_IRQ_CLR, 32'h1F);
        wr(EIP_OFS_IRQ_EN, 32'h0);
        u_eip_pin_src.drive(3, 1'b0, 6);
        chk("irq_masked", 32'h0, irq);
        wr(EIP_OFS_IRQ_EN, 32'h8);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, irq);
        wr(EIP_OFS_IRQ_CLR, 32'h8);
        repeat (2) @(posedge pclk);
        chk("irq_clr", 32'h0, irq);
        u_eip_pin_src.drive(3, 1'b1, 2);
        for (int k = 0; k < 16; k++) begin
            v = $urandom;
            wr(EIP_OFS_IRQ_EN, v);
            rdc("irq_en", EIP_OFS_IRQ_EN, v & 32'h1F);
            wr(EIP_OFS_CLKO, v);
            rdc("clko", EIP_OFS_CLKO, v & 32'h5);
            chk("oe_n_c0", !v[2], c0n);
            chk("oe_n_c5", !v[0], c5n);
        end
        // Master clock has period 4, so 64 cycles give 32 changes undivided
        for (int s = 0; s < 4; s++) begin
            wr(EIP_OFS_CTRL, s << EIP_CTRL_DIV_LO);
            repeat (8) @(posedge pclk);
            tg = 0;
            r[0] = mco;
            repeat (64) begin
                @(posedge pclk);
                tg += (mco !== r[0]);
                r[0] = mco;
            end
            chk("mclk_oe_n", s == 0, mcon);
            if (s > 0) chk("mclk_div", 32'h1, (tg - (32 >> (s - 1))) inside {[-1:1]});
        end
        wr(EIP_OFS_CTRL, 32'h40);
        repeat (2) @(posedge pclk);
        chk("reset_ind_hi", 32'h1, rsto);
        u_eip_pin_src.drive(2, 1'b0, 4);
        opt <= 1'b1;
        u_eip_pin_src.drive(2, 1'b1, 0);
        u_eip_pin_src.drive(2, 1'b0, 8);
        chk("pin_rst_short", 32'h0, prr);
        u_eip_pin_src.drive(2, 1'b1, 8);
        chk("pin_rst", 32'h1, prr);
        chk("reset_ind_lo", 32'h0, rsto);
        u_eip_pin_src.drive(2, 1'b0, 8);
        opt <= 1'b0;
        rdc("ctrl_cleared", EIP_OFS_CTRL, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
